//--- logic/gp_config_pkg.sv
// constants for the general-purpose configuration register bank
package gp_config_pkg;
   // register map and frame layout
   localparam logic [4:0]  CFG_ADDR        = 5'h09;
   localparam logic [15:0] CFG_RESET_LOW   = 16'h0204;
   localparam logic [23:0] CFG_RESET_FRAME = 24'h09_0204;
   localparam int          FRAME_W         = 24;
   localparam int          DATA_W          = 16;
   localparam int          ADDR_W          = 5;
   localparam int          FAULT_BIT       = 21;
   localparam int          ADDR_LSB        = 16;
   localparam int          ADDR_MSB        = 20;
   // field positions
   localparam int RSVD_HI_MSB    = 15;
   localparam int RSVD_HI_LSB    = 14;
   localparam int TEMP_MSB       = 13;
   localparam int TEMP_LSB       = 12;
   localparam int CLKCTL_MSB     = 11;
   localparam int CLKCTL_LSB     = 10;
   localparam int RATE_MSB       = 9;
   localparam int RATE_LSB       = 7;
   localparam int MODEM_BIT      = 6;
   localparam int SHIFT_BIT      = 5;
   localparam int IMMCLR_BIT     = 4;
   localparam int MUTE_BIT       = 3;
   localparam int LOSS_BIT       = 2;
   localparam int RSVD_LO_MSB    = 1;
   localparam int RSVD_LO_LSB    = 0;
   // field encodings
   localparam logic [1:0] CLKCTL_OFF = 2'h0;
   localparam logic [1:0] CLKCTL_ON  = 2'h1;
   localparam logic [1:0] TEMP_142C  = 2'h0;
   localparam logic [1:0] TEMP_127C  = 2'h1;
   localparam logic [1:0] TEMP_112C  = 2'h2;
   localparam logic [1:0] TEMP_97C   = 2'h3;
   localparam logic [2:0] RATE_500K  = 3'h4;
   localparam logic [23:0] LOSS_CODE = 24'h07_DEAD;
   // clock output rates in kHz, index is the rate code
   localparam int CLK_KHZ = 100000;
   localparam int RATE_KHZ [8] = '{416, 435, 454, 476, 500, 526, 555, 588};
   localparam int HALF_W = 8;
   // half period in clk_i cycles, rounded to nearest
   function automatic logic [HALF_W-1:0] half_count(input logic [2:0] code);
      int f;
      f = RATE_KHZ[code];
      half_count = HALF_W'((CLK_KHZ + f) / (2 * f));
   endfunction
   // clear sequencing states
   typedef enum logic [2:0] {
      CLR_IDLE = 3'b001,
      CLR_JUMP = 3'b010,
      CLR_RAMP = 3'b100
   } clear_state_t;
endpackage

//--- logic/rate_divider.sv
// toggle divider that forms the clock output pin
`timescale 1ns/100ps
module rate_divider
   import gp_config_pkg::*;
#(
   parameter int W = HALF_W
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] half_i,
   output logic              clk_out_o
);
   logic [W-1:0] count;

   // count half periods, hold low while stopped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count     <= '0;
         clk_out_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_i) begin
            count     <= '0;
            clk_out_o <= 1'b0;
         end else if (count >= half_i - W'(1)) begin
            count     <= '0;
            clk_out_o <= ~clk_out_o;
         end else begin
            count <= count + W'(1);
         end
      end
   end
endmodule

//--- logic/general_purpose_config_bank.sv
// general-purpose configuration register with its control outputs
`timescale 1ns/100ps
module general_purpose_config_bank
   import gp_config_pkg::*;
#(
   parameter int RW = HALF_W
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               ce_i,
   // register access from the serial frame decoder
   input  wire logic               wr_en_i,
   input  wire logic               rd_en_i,
   input  wire logic [ADDR_W-1:0]  addr_i,
   input  wire logic [DATA_W-1:0]  wdata_i,
   output logic [FRAME_W-1:0]      rdata_o,
   output logic                    rvalid_o,
   output logic                    hit_o,
   // fault pin and error sources
   input  wire logic               fault_pin_i,
   input  wire logic               crc_error_i,
   input  wire logic               slip_flag_error_i,
   input  wire logic               sclk_count_error_i,
   input  wire logic               other_fault_i,
   output logic                    digital_fault_summary_o,
   output logic                    fault_pin_request_o,
   // analog controls
   output logic [1:0]              temp_trip_select_o,
   output logic                    modem_path_enable_o,
   output logic                    below_zero_shift_enable_o,
   output logic                    clock_output_pin_o,
   // clear sequencing
   input  wire logic               clear_req_i,
   input  wire logic               slew_enable_i,
   input  wire logic               ramp_done_i,
   output logic                    clear_jump_o,
   output logic                    clear_ramp_o,
   // serial data override on clock loss
   input  wire logic               mclk_stopped_i,
   output logic                    sdo_override_o,
   output logic [FRAME_W-1:0]      sdo_code_o
);
   logic [DATA_W-1:0] cfg;
   logic              wr_hit;
   logic              rd_hit;
   logic [DATA_W-1:0] cfg_view;
   logic [1:0]        clk_ctl;
   logic              link_err;
   logic              link_err_kept;
   logic              clk_run;
   logic [RW-1:0]     half_period;
   clear_state_t      clr_state;
   clear_state_t      next_clr_state;

   assign wr_hit = wr_en_i && (addr_i == CFG_ADDR);
   assign rd_hit = rd_en_i && (addr_i == CFG_ADDR);
   assign hit_o  = wr_hit || rd_hit;

   // register storage, bits 15:14 are not stored
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg <= CFG_RESET_LOW;
      end else if (ce_i && wr_hit) begin
         cfg <= wdata_i;
         cfg[RSVD_HI_MSB:RSVD_HI_LSB] <= 2'h0;
      end
   end

   assign cfg_view = {2'h0, cfg[TEMP_MSB:0]};

   // read frame: fault status, address echo, data
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o  <= '0;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= rd_hit;
         if (rd_hit) begin
            rdata_o                   <= '0;
            rdata_o[FAULT_BIT]        <= ~fault_pin_i;
            rdata_o[ADDR_MSB:ADDR_LSB] <= addr_i;
            rdata_o[DATA_W-1:0]       <= cfg_view;
         end
      end
   end

   // plain field decode
   assign temp_trip_select_o        = cfg[TEMP_MSB:TEMP_LSB];
   assign modem_path_enable_o       = cfg[MODEM_BIT];
   assign below_zero_shift_enable_o = cfg[SHIFT_BIT];
   assign clk_ctl                   = cfg[CLKCTL_MSB:CLKCTL_LSB];

   // only code 01 runs the clock pin; reserved codes stay idle
   assign clk_run     = (clk_ctl == CLKCTL_ON);
   assign half_period = RW'(half_count(cfg[RATE_MSB:RATE_LSB]));

   rate_divider #(
      .W         (RW)
   ) u_rate_divider (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .run_i     (clk_run),
      .half_i    (half_period),
      .clk_out_o (clock_output_pin_o)
   );

   // fault summary with optional link error mute
   assign link_err      = crc_error_i || slip_flag_error_i ||
                          sclk_count_error_i;
   assign link_err_kept = link_err && !cfg[MUTE_BIT];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         digital_fault_summary_o <= 1'b0;
         fault_pin_request_o     <= 1'b0;
      end else if (ce_i) begin
         digital_fault_summary_o <= link_err_kept;
         fault_pin_request_o     <= link_err_kept || other_fault_i;
      end
   end

   // clock loss override on serial data out
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sdo_override_o <= 1'b0;
      end else if (ce_i) begin
         sdo_override_o <= cfg[LOSS_BIT] && mclk_stopped_i;
      end
   end
   assign sdo_code_o = LOSS_CODE;

   // clear sequencing: jump at once or follow the slew ramp
   always_comb begin
      next_clr_state = clr_state;
      case (clr_state)
         CLR_IDLE: begin
            if (clear_req_i) begin
               if (slew_enable_i && !cfg[IMMCLR_BIT]) begin
                  next_clr_state = CLR_RAMP;
               end else begin
                  next_clr_state = CLR_JUMP;
               end
            end
         end
         CLR_JUMP: begin
            next_clr_state = CLR_IDLE;
         end
         CLR_RAMP: begin
            if (ramp_done_i) begin
               next_clr_state = CLR_IDLE;
            end else if (cfg[IMMCLR_BIT]) begin
               next_clr_state = CLR_JUMP;
            end
         end
         default: begin
            next_clr_state = CLR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         clr_state <= CLR_IDLE;
      end else if (ce_i) begin
         clr_state <= next_clr_state;
      end
   end

   assign clear_jump_o = (clr_state == CLR_JUMP);
   assign clear_ramp_o = (clr_state == CLR_RAMP);

   // checks on the bank's own outputs
   sequence s_write_cfg;
      ce_i && wr_hit;
   endsequence

   sequence s_read_cfg;
      ce_i && rd_hit;
   endsequence

   AST_RESET_VALUE: assert property (
      @(posedge clk_i) $rose(rst_n_i) |-> cfg_view == CFG_RESET_LOW)
      else $error("bank not at reset value after reset");

   AST_FAULT_INVERT: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_read_cfg |=> rdata_o[FAULT_BIT] == !$past(fault_pin_i))
      else $error("fault status bit not inverted pin level");

   AST_ADDR_ECHO: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_read_cfg |=> rvalid_o && rdata_o[ADDR_MSB:ADDR_LSB] == CFG_ADDR
         && rdata_o[FRAME_W-1:FAULT_BIT+1] == 2'h0)
      else $error("address echo wrong in read frame");

   AST_WRITE_READ: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_write_cfg |=> temp_trip_select_o == $past(wdata_i[TEMP_MSB:TEMP_LSB])
         && cfg_view[RATE_MSB:RATE_LSB] == $past(wdata_i[RATE_MSB:RATE_LSB]))
      else $error("thermal trip field not taken from write");

   AST_RSVD_ZERO: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_read_cfg |=> rdata_o[RSVD_HI_MSB:RSVD_HI_LSB] == 2'h0)
      else $error("reserved high bits read nonzero");

   AST_CLK_IDLE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !clk_run) [*2] |-> !clock_output_pin_o)
      else $error("clock pin toggles while disabled");

   // cycles the running clock pin has held one level
   logic          pin_last;
   logic [RW-1:0] half_last;
   logic [RW:0]   quiet_count;

   // restarts on a toggle, a stop or a rate change
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_last    <= 1'b0;
         half_last   <= '0;
         quiet_count <= '0;
      end else if (ce_i) begin
         pin_last  <= clock_output_pin_o;
         half_last <= half_period;
         if (!clk_run || clock_output_pin_o != pin_last ||
             half_period != half_last) begin
            quiet_count <= '0;
         end else begin
            quiet_count <= quiet_count + (RW+1)'(1);
         end
      end
   end

   AST_CLK_TOGGLES: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && clk_run && half_period == half_last) |->
         quiet_count <= {1'b0, half_period})
      else $error("clock pin held longer than its half period");

   AST_MUTE_SUMMARY: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && cfg[MUTE_BIT] && !other_fault_i) |=>
         !digital_fault_summary_o && !fault_pin_request_o)
      else $error("muted link error reached fault summary");

   AST_UNMUTED_FAULT: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !cfg[MUTE_BIT] && link_err) |=>
         digital_fault_summary_o && fault_pin_request_o)
      else $error("link error lost while not muted");

   AST_LOSS_CODE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && cfg[LOSS_BIT] && mclk_stopped_i) |=>
         sdo_override_o && sdo_code_o == LOSS_CODE)
      else $error("clock loss code not presented");

   AST_CLEAR_NOW: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && clr_state == CLR_IDLE && clear_req_i && cfg[IMMCLR_BIT])
         |=> clear_jump_o ##1 !clear_ramp_o)
      else $error("immediate clear did not jump");

   AST_CLEAR_RAMP: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && clr_state == CLR_IDLE && clear_req_i && slew_enable_i
         && !cfg[IMMCLR_BIT]) |=> clear_ramp_o && !clear_jump_o)
      else $error("slewed clear jumped instead of ramping");

   AST_MODEM_SHIFT: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_write_cfg |=> modem_path_enable_o == $past(wdata_i[MODEM_BIT])
         && below_zero_shift_enable_o == $past(wdata_i[SHIFT_BIT]))
      else $error("modem or shift enable not taken from write");

   AST_RVALID_PULSE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !rd_hit) |=> !rvalid_o)
      else $error("read valid without an accepted read");

   AST_JUMP_ONCE: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && clear_jump_o) |=> !clear_jump_o)
      else $error("clear jump longer than one cycle");

   AST_LOSS_OFF: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !cfg[LOSS_BIT]) |=> !sdo_override_o)
      else $error("clock loss code shown while detection is off");
endmodule

//--- verification/host_model.sv
// host side model driving the register strobe port
`timescale 1ns/100ps
module host_model
   import gp_config_pkg::*;
(
   input  wire logic          clk_i,
   output logic              wr_en_o,
   output logic              rd_en_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o
);
   // idle bus at start
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o  = '0;
      wdata_o = '0;
   end
   // one strobe cycle per access
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      wr_en_o <= w;
      rd_en_o <= ~w;
      addr_o  <= a;
      // reserved bits at default, reserved clock codes never sent
      wdata_o <= {2'b00, d[13:12], 1'b0, d[10:2], 2'b00};
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b0;
      // released bus shows inverted values, not the last ones
      addr_o  <= ~a;
      wdata_o <= ~wdata_o;
   endtask
endmodule

//--- verification/general_purpose_config_bank_tb.sv
// self-checking bench for the general-purpose configuration bank
`timescale 1ns/100ps
module general_purpose_config_bank_tb
   import gp_config_pkg::*;
;
   logic               clk_i, rst_n_i, ce_i, wr_en_i, rd_en_i;
   logic               rvalid_o, hit_o, fault_pin_i, crc_error_i;
   logic               slip_flag_error_i, sclk_count_error_i;
   logic               other_fault_i, digital_fault_summary_o;
   logic               fault_pin_request_o, modem_path_enable_o;
   logic               below_zero_shift_enable_o, clock_output_pin_o;
   logic               clear_req_i, slew_enable_i, ramp_done_i;
   logic               clear_jump_o, clear_ramp_o;
   logic               mclk_stopped_i, sdo_override_o;
   logic [1:0]         temp_trip_select_o;
   logic [ADDR_W-1:0]  addr_i;
   logic [DATA_W-1:0]  wdata_i, cfg;
   logic [FRAME_W-1:0] rdata_o, sdo_code_o;
   int                 bad_count = 0;
   int                 total_checks = 0;
   int                 hits = 0;
   int                 half_tab [8] = '{120, 115, 110, 105, 100, 95, 90, 85};

   general_purpose_config_bank i_dut (.clk_i, .rst_n_i, .ce_i, .wr_en_i,
      .rd_en_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o, .hit_o,
      .fault_pin_i, .crc_error_i, .slip_flag_error_i, .sclk_count_error_i,
      .other_fault_i, .digital_fault_summary_o, .fault_pin_request_o,
      .temp_trip_select_o, .modem_path_enable_o, .below_zero_shift_enable_o,
      .clock_output_pin_o, .clear_req_i, .slew_enable_i, .ramp_done_i,
      .clear_jump_o, .clear_ramp_o, .mclk_stopped_i, .sdo_override_o,
      .sdo_code_o);
   host_model i_host (.clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
      .addr_o(addr_i), .wdata_o(wdata_i));

   // count edges at which the bank claims a strobe
   always @(posedge clk_i) begin
      hits <= hits + int'(hit_o === 1'b1);
   end

   // free-running clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input string nm, input logic [23:0] e,
                        input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wcfg(input logic [15:0] d);
      i_host.access(1'b1, CFG_ADDR, d);
      cfg = {2'b00, d[13:12], 1'b0, d[10:2], 2'b00};
      #1;
   endtask

   task automatic rdchk();
      int h0;
      h0 = hits;
      i_host.access(1'b0, CFG_ADDR, 16'h0000);
      #1;
      check("rvalid", 24'h00_0001, 24'(rvalid_o));
      check("rdata", {2'b00, ~fault_pin_i, CFG_ADDR, cfg},
            rdata_o);
      check("hit", 24'(h0 + 1), 24'(hits));
   endtask

   task automatic wait_pin(input logic v);
      int n = 0;
      while (clock_output_pin_o !== v && n < 1000) begin
         tick(1);
         n++;
      end
      if (n >= 1000) begin
         check("pin_wait", 24'(v), 24'(clock_output_pin_o));
      end
   endtask

   task automatic t_reset();
      cfg = 16'h0204;
      check("pin_idle", 24'h0, 24'(clock_output_pin_o));
      check("temp", 24'h0, 24'(temp_trip_select_o));
      rdchk();
   endtask

   task automatic t_fields();
      logic [1:0] t;
      int         h;
      for (int i = 0; i < 4; i++) begin
         t = 2'(i);
         @(posedge clk_i);
         fault_pin_i <= t[0];
         wcfg({2'b11, t, 2'b00, 3'h4, t[0], t[1], 5'h1F});
         check("temp", 24'(t), 24'(temp_trip_select_o));
         check("modem", 24'(t[0]), 24'(modem_path_enable_o));
         check("shift", 24'(t[1]), 24'(below_zero_shift_enable_o));
         rdchk();
      end
      // another address is ignored and gives no answer
      h = hits;
      i_host.access(1'b1, 5'h0A, 16'h0000);
      i_host.access(1'b0, 5'h0A, 16'h0000);
      #1;
      check("rvalid_other", 24'h0, 24'(rvalid_o));
      check("hit_other", 24'(h), 24'(hits));
      rdchk();
   endtask

   task automatic t_clock();
      int n;
      for (int r = 0; r < 8; r++) begin
         wcfg({6'h01, 3'(r), 7'h04});
         for (int k = 0; k < 4; k++) begin
            wait_pin(k[0]);
         end
         n = 0;
         while (clock_output_pin_o === 1'b1 && n < 300) begin
            n++;
            tick(1);
         end
         check("half_period", 24'(half_tab[r]), 24'(n));
      end
      wcfg(16'h0204);
      tick(2);
      n = 0;
      repeat (300) begin
         @(posedge clk_i);
         n += int'(clock_output_pin_o !== 1'b0);
      end
      check("pin_off", 24'h0, 24'(n));
   endtask

   task automatic t_mute();
      logic [2:0] e;
      for (int m = 0; m < 2; m++) begin
         wcfg({12'h000, m[0], 3'h4});
         for (int i = 0; i < 4; i++) begin
            e = (i == 3) ? 3'h0 : 3'(1 << i);
            @(posedge clk_i);
            {crc_error_i, slip_flag_error_i, sclk_count_error_i} <= e;
            other_fault_i <= (i == 3);
            tick(2);
            check("summary", 24'(e != 0 && m == 0),
                  24'(digital_fault_summary_o));
            check("fault_req", 24'((e != 0 && m == 0) || i == 3),
                  24'(fault_pin_request_o));
         end
      end
      @(posedge clk_i);
      {crc_error_i, slip_flag_error_i, sclk_count_error_i} <= 3'h0;
      other_fault_i <= 1'b0;
   endtask

   task automatic pulse_clear();
      @(posedge clk_i);
      clear_req_i <= 1'b1;
      @(posedge clk_i);
      clear_req_i <= 1'b0;
      #1;
   endtask

   task automatic t_clear();
      wcfg(16'h0004);
      @(posedge clk_i);
      slew_enable_i <= 1'b1;
      pulse_clear();
      check("jump", 24'h0, 24'(clear_jump_o));
      tick(3);
      check("ramp_hold", 24'h1, 24'(clear_ramp_o));
      @(posedge clk_i);
      ramp_done_i <= 1'b1;
      tick(2);
      check("ramp_end", 24'h0, 24'(clear_ramp_o));
      @(posedge clk_i);
      ramp_done_i <= 1'b0;
      wcfg(16'h0014);
      pulse_clear();
      check("jump_now", 24'h1, 24'(clear_jump_o));
      check("no_ramp", 24'h0, 24'(clear_ramp_o));
      tick(1);
      check("jump_once", 24'h0, 24'(clear_jump_o));
      @(posedge clk_i);
      slew_enable_i <= 1'b0;
   endtask

   task automatic t_loss();
      for (int b = 0; b < 2; b++) begin
         wcfg({13'h0000, b[0], 2'b00});
         @(posedge clk_i);
         mclk_stopped_i <= 1'b1;
         tick(2);
         check("override", 24'(b), 24'(sdo_override_o));
         check("code", 24'h07_DEAD, sdo_code_o);
         @(posedge clk_i);
         mclk_stopped_i <= 1'b0;
         tick(2);
         check("release", 24'h0, 24'(sdo_override_o));
      end
   endtask

   // frozen write is refused, then a mid-run reset restores defaults
   task automatic t_freeze();
      @(posedge clk_i);
      ce_i <= 1'b0;
      i_host.access(1'b1, CFG_ADDR, 16'h3000);
      #1;
      check("frozen", 24'(cfg[TEMP_MSB:TEMP_LSB]),
            24'(temp_trip_select_o));
      @(posedge clk_i);
      ce_i <= 1'b1;
      rdchk();
      wcfg(16'h3000);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      cfg = CFG_RESET_LOW;
      rdchk();
      check("temp_rst", 24'h0, 24'(temp_trip_select_o));
   endtask

   // reset, then the scenarios in turn
   initial begin
      {rst_n_i, clear_req_i, slew_enable_i, ramp_done_i} = 4'h0;
      {fault_pin_i, crc_error_i, slip_flag_error_i} = 3'h0;
      {sclk_count_error_i, other_fault_i, mclk_stopped_i} = 3'h0;
      ce_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_fields();
      t_clock();
      t_mute();
      t_clear();
      t_loss();
      t_freeze();
      summarize();
   end

   // watchdog well beyond the expected run
   initial begin
      #200_000;
      bad_count++;
      summarize();
   end
endmodule
